// ==== pkg/bridge_cfg_defs.svh ====
// Offsets, field positions, reset values for the bridge header registers
// Assumes byte-addressed configuration space, dword reads with byte enables
`ifndef BRIDGE_CFG_DEFS_SVH
`define BRIDGE_CFG_DEFS_SVH
`define OFF_PRI_LAT 8'h0D
`define OFF_HDR_TYPE 8'h0E
`define OFF_SELF_TEST 8'h0F
`define OFF_BASE_WIN0 8'h10
`define OFF_BASE_WIN1 8'h14
`define OFF_UP_BUS 8'h18
`define OFF_DN_BUS 8'h19
`define OFF_HI_BUS 8'h1A
`define OFF_DN_LAT 8'h1B
`define OFF_IO_BOT 8'h1C
`define OFF_IO_TOP 8'h1D
`define OFF_BRIDGE_LO 8'h10
`define OFF_BRIDGE_HI 8'h3F
`define RST_LAT 8'h00
`define RST_BUS 8'h00
`define VAL_HDR_TYPE 8'h01
`define VAL_SELF_TEST 8'h00
`define VAL_BASE_WIN 32'h0000_0000
`define VAL_IO_CAP 4'h1
`define IO_LOW_BOT 12'h000
`define IO_LOW_TOP 12'hFFF
`define IO_FLD_MSB 7
`define IO_FLD_LSB 4
`endif

// ==== pkg/bridge_cfg_pkg.sv ====
// Types shared by the bridge header register bank
// Assumes nothing beyond the defines header
package bridge_cfg_pkg;
  // Configuration access from the primary side
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_s;
  // Type 1 configuration cycle seen on the primary bus
  typedef struct packed {
    logic valid;
    logic [7:0] bus;
  } fwd_req_s;
  // Forwarding decision
  typedef enum logic [1:0] {FWD_NONE, FWD_TYPE0, FWD_TYPE1} fwd_kind_e;
  // Initiator tenure phases
  typedef enum logic [1:0] {TEN_IDLE, TEN_RUN, TEN_EXPIRED} tenure_e;
endpackage : bridge_cfg_pkg

// ==== hw/bridge_config_header_regs.sv ====
// Bridge header registers 0Dh..1Dh, latency timers, config forwarding, I/O window
// Assumes a config port on the primary side; all inputs synchronous to clk
// Contract
// - Primary timer counts from zero at frame
// - Secondary timer expiry ends once grant removed
// - Internal secondary grant drops on other request
// - Header type reads fixed 01h
// - Bridge layout covers bytes 10h to 3Fh
// - Self-test unsupported, reads 00h
// - First base window reads zero, ignores writes
// - Second base window reads zero
// - Three bus numbers read/write, reset zero
// - Highest bus id bounds forwarding
// - Downstream bus match becomes type 0
// - Other subordinate bus stays type 1
// - I/O window low nibble fixed 0001b
// - I/O window upper nibble is address 15:12
// - Window bottom low 12 bits zero
// - Window top low 12 bits FFFh
// - Upper 16 bits from upper-half registers
`timescale 1ns/1ps
`include "bridge_cfg_defs.svh"
module bridge_config_header_regs
  import bridge_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration access
  input wire cfg_req_s cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  output logic cfg_in_bridge_layout,
  // Primary initiator
  input wire logic pri_frame_start,
  input wire logic pri_busy,
  input wire logic pri_gnt,
  output logic pri_end_req,
  // Secondary initiator and arbitration
  input wire logic sec_frame_start,
  input wire logic sec_busy,
  input wire logic sec_own_grant,
  input wire logic sec_other_req,
  output logic sec_gnt_int,
  output logic sec_end_req,
  // Configuration forwarding
  input wire fwd_req_s fwd_req,
  output fwd_kind_e fwd_kind,
  // I/O window from upper-half registers
  input wire logic [15:0] io_bot_upper,
  input wire logic [15:0] io_top_upper,
  output logic [31:0] io_win_bot,
  output logic [31:0] io_win_top
);

  // Byte lane merge for a read/write 8-bit field
  function automatic logic [7:0] lane_wr(input logic [7:0] cur, input cfg_req_s r, input logic [7:0] off);
    logic [1:0] ln;
    ln = off[1:0];
    lane_wr = cur;
    if (r.valid && r.write && (r.addr[7:2] == off[7:2]) && r.be[ln]) begin
      lane_wr = r.wdata[8*ln +: 8];
    end
  endfunction : lane_wr

  // Software registers
  logic [7:0] pri_lat_r, pri_lat_nxt; // Primary latency count
  logic [7:0] up_bus_r, up_bus_nxt; // Upstream bus id
  logic [7:0] dn_bus_r, dn_bus_nxt; // Downstream bus id
  logic [7:0] hi_bus_r, hi_bus_nxt; // Highest bus id
  logic [7:0] dn_lat_r, dn_lat_nxt; // Downstream latency count
  logic [3:0] io_bot_r, io_bot_nxt; // Window bottom writable nibble
  logic [3:0] io_top_r, io_top_nxt; // Window top writable nibble
  logic [31:0] rdata_r, rdata_nxt; // Read data
  logic ack_r, ack_nxt; // Access answer
  logic [7:0] io_bot_b, io_top_b; // Full byte views
  logic [7:0] io_bot_w, io_top_w; // Window bytes after write merge

  // Register writes
  always_comb begin
    up_bus_nxt = lane_wr(up_bus_r, cfg_req, `OFF_UP_BUS);
    dn_bus_nxt = lane_wr(dn_bus_r, cfg_req, `OFF_DN_BUS);
    hi_bus_nxt = lane_wr(hi_bus_r, cfg_req, `OFF_HI_BUS);
    pri_lat_nxt = lane_wr(pri_lat_r, cfg_req, `OFF_PRI_LAT);
    dn_lat_nxt = lane_wr(dn_lat_r, cfg_req, `OFF_DN_LAT);
    io_bot_w = lane_wr({io_bot_r, `VAL_IO_CAP}, cfg_req, `OFF_IO_BOT);
    io_top_w = lane_wr({io_top_r, `VAL_IO_CAP}, cfg_req, `OFF_IO_TOP);
    // Capability nibble written by software is dropped
    io_bot_nxt = io_bot_w[`IO_FLD_MSB:`IO_FLD_LSB];
    io_top_nxt = io_top_w[`IO_FLD_MSB:`IO_FLD_LSB];
  end

  assign io_bot_b = {io_bot_r, `VAL_IO_CAP};
  assign io_top_b = {io_top_r, `VAL_IO_CAP};

  // Read mux; one-cycle answer
  always_comb begin
    ack_nxt = cfg_req.valid;
    rdata_nxt = rdata_r;
    if (cfg_req.valid && !cfg_req.write) begin
      unique case (cfg_req.addr[7:2])
        6'h03: rdata_nxt = {`VAL_SELF_TEST, `VAL_HDR_TYPE, pri_lat_r, 8'h00};
        6'h04: rdata_nxt = `VAL_BASE_WIN;
        6'h05: rdata_nxt = `VAL_BASE_WIN;
        6'h06: rdata_nxt = {dn_lat_r, hi_bus_r, dn_bus_r, up_bus_r};
        6'h07: rdata_nxt = {16'h0000, io_top_b, io_bot_b};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Register state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pri_lat_r <= `RST_LAT;
      up_bus_r <= `RST_BUS;
      dn_bus_r <= `RST_BUS;
      hi_bus_r <= `RST_BUS;
      dn_lat_r <= `RST_LAT;
      io_bot_r <= 4'h0;
      io_top_r <= 4'h0;
      rdata_r <= 32'h0000_0000;
      ack_r <= 1'b0;
    end else begin
      pri_lat_r <= pri_lat_nxt;
      up_bus_r <= up_bus_nxt;
      dn_bus_r <= dn_bus_nxt;
      hi_bus_r <= hi_bus_nxt;
      dn_lat_r <= dn_lat_nxt;
      io_bot_r <= io_bot_nxt;
      io_top_r <= io_top_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
    end
  end

  assign cfg_rdata = rdata_r;
  assign cfg_ack = ack_r;
  assign cfg_in_bridge_layout = (cfg_req.addr >= `OFF_BRIDGE_LO) && (cfg_req.addr <= `OFF_BRIDGE_HI);

  // Latency timers: tenure phase, clocks since frame, internal grant
  tenure_e pri_st_r, pri_st_nxt; // Primary tenure phase
  tenure_e sec_st_r, sec_st_nxt; // Secondary tenure phase
  logic [7:0] pri_cnt_r, pri_cnt_nxt; // Primary clocks since frame
  logic [7:0] sec_cnt_r, sec_cnt_nxt; // Secondary clocks since frame
  logic sec_gnt_r, sec_gnt_nxt; // Internal secondary grant

  // Primary tenure next state
  always_comb begin
    // Hold unless an event moves the phase
    pri_st_nxt = pri_st_r;
    pri_cnt_nxt = pri_cnt_r;
    unique case (pri_st_r)
      TEN_IDLE: if (pri_frame_start) begin
        pri_st_nxt = TEN_RUN;
        pri_cnt_nxt = 8'h00;
      end
      // Counting while the transaction runs
      TEN_RUN: begin
        if (!pri_busy) begin
          // Finished before expiry
          pri_st_nxt = TEN_IDLE;
        end else if (pri_cnt_r >= pri_lat_r) begin
          // Count reached the programmed latency
          pri_st_nxt = TEN_EXPIRED;
        end else begin
          // One more clock of tenure
          pri_cnt_nxt = pri_cnt_r + 8'h01;
        end
      end
      // Expired: wait for the transaction to end
      TEN_EXPIRED: if (!pri_busy) pri_st_nxt = TEN_IDLE;
      // Unused encoding returns to idle
      default: pri_st_nxt = TEN_IDLE;
    endcase
  end

  // Primary tenure registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pri_st_r <= TEN_IDLE;
      pri_cnt_r <= 8'h00;
    end else begin
      pri_st_r <= pri_st_nxt;
      pri_cnt_r <= pri_cnt_nxt;
    end
  end

  // Secondary tenure next state
  always_comb begin
    // Hold unless an event moves the phase
    sec_st_nxt = sec_st_r;
    sec_cnt_nxt = sec_cnt_r;
    unique case (sec_st_r)
      TEN_IDLE: if (sec_frame_start) begin
        sec_st_nxt = TEN_RUN;
        sec_cnt_nxt = 8'h00;
      end
      // Counting while the transaction runs
      TEN_RUN: begin
        if (!sec_busy) begin
          // Finished before expiry
          sec_st_nxt = TEN_IDLE;
        end else if (sec_cnt_r >= dn_lat_r) begin
          // Count reached the programmed latency
          sec_st_nxt = TEN_EXPIRED;
        end else begin
          // One more clock of tenure
          sec_cnt_nxt = sec_cnt_r + 8'h01;
        end
      end
      // Expired: wait for the transaction to end
      TEN_EXPIRED: if (!sec_busy) sec_st_nxt = TEN_IDLE;
      // Unused encoding returns to idle
      default: sec_st_nxt = TEN_IDLE;
    endcase
  end

  // Secondary tenure registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_st_r <= TEN_IDLE;
      sec_cnt_r <= 8'h00;
    end else begin
      sec_st_r <= sec_st_nxt;
      sec_cnt_r <= sec_cnt_nxt;
    end
  end

  always_comb begin
    // Arbiter grant, dropped while another master asks
    sec_gnt_nxt = sec_own_grant && !sec_other_req;
  end

  // Internal grant register, one clock behind the arbiter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_gnt_r <= 1'b0;
    end else begin
      sec_gnt_r <= sec_gnt_nxt;
    end
  end

  // Grant as seen by the secondary tenure
  assign sec_gnt_int = sec_gnt_r;
  assign pri_end_req = (pri_st_r == TEN_EXPIRED) && pri_busy && !pri_gnt;
  assign sec_end_req = (sec_st_r == TEN_EXPIRED) && sec_busy && !sec_gnt_r;

  // Forwarding decision
  fwd_kind_e fwd_r, fwd_nxt; // Registered cycle kind

  // Forwarding next decision
  always_comb begin
    // No forward unless the bus lies behind the bridge
    fwd_nxt = FWD_NONE;
    if (fwd_req.valid && (fwd_req.bus >= dn_bus_r) && (fwd_req.bus <= hi_bus_r)) begin
      if (fwd_req.bus == dn_bus_r) begin
        // Aimed at the downstream bus itself
        fwd_nxt = FWD_TYPE0;
      end else begin
        // Further down, passed on unchanged
        fwd_nxt = FWD_TYPE1;
      end
    end
  end

  // Forwarding decision register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_r <= FWD_NONE;
    end else begin
      fwd_r <= fwd_nxt;
    end
  end

  // Window addresses
  logic [31:0] bot_r, bot_nxt; // Window bottom address
  logic [31:0] top_r, top_nxt; // Window top address

  // Window next addresses
  always_comb begin
    bot_nxt = {io_bot_upper, io_bot_r, `IO_LOW_BOT};
    top_nxt = {io_top_upper, io_top_r, `IO_LOW_TOP};
  end

  // Window registers; reset shows the lowest window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bot_r <= 32'h0000_0000;
      top_r <= 32'h0000_0FFF;
    end else begin
      bot_r <= bot_nxt;
      top_r <= top_nxt;
    end
  end

  // Registered outputs
  assign fwd_kind = fwd_r;
  assign io_win_bot = bot_r;
  assign io_win_top = top_r;

endmodule : bridge_config_header_regs

// ==== test/bridge_hdr_chk.sv ====
// Port checker for the bridge header bank
// Assumes one clk domain with async active-low rst_n
`timescale 1ns/1ps
module bridge_hdr_chk
  import bridge_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Config port
  input wire cfg_req_s cfg_req,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_ack,
  input wire logic cfg_in_bridge_layout,
  // Initiators
  input wire logic pri_busy,
  input wire logic pri_gnt,
  input wire logic pri_end_req,
  input wire logic sec_busy,
  input wire logic sec_own_grant,
  input wire logic sec_other_req,
  input wire logic sec_gnt_int,
  input wire logic sec_end_req,
  // I/O window
  input wire logic [15:0] io_bot_upper,
  input wire logic [31:0] io_win_bot,
  input wire logic [31:0] io_win_top
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Read access at one address
  sequence s_rd(a);
    cfg_req.valid && !cfg_req.write && cfg_req.addr == a;
  endsequence
  property p_ack; $past(rst_n) |-> cfg_ack == $past(cfg_req.valid); endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after access");
  property p_hdr; s_rd(8'h0C) |=> cfg_rdata[31:16] == 16'h0001; endproperty
  a_hdr: assert property (p_hdr) else $error("header or self-test byte wrong");
  property p_bar; (s_rd(8'h10) or s_rd(8'h14)) |=> cfg_rdata == 32'h0; endproperty
  a_bar: assert property (p_bar) else $error("base window not zero");
  property p_io; s_rd(8'h1C) |=> cfg_rdata[3:0] == 4'h1 && cfg_rdata[11:8] == 4'h1; endproperty
  a_io: assert property (p_io) else $error("window low nibble wrong");
  property p_lay; cfg_in_bridge_layout == (cfg_req.addr >= 8'h10 && cfg_req.addr <= 8'h3F); endproperty
  a_lay: assert property (p_lay) else $error("layout flag wrong");
  property p_low; io_win_bot[11:0] == 12'h000 && io_win_top[11:0] == 12'hFFF; endproperty
  a_low: assert property (p_low) else $error("window low bits wrong");
  property p_up; $past(rst_n) |-> io_win_bot[31:16] == $past(io_bot_upper); endproperty
  a_up: assert property (p_up) else $error("window upper half wrong");
  property p_gnt; $past(rst_n) |-> sec_gnt_int == ($past(sec_own_grant) && !$past(sec_other_req)); endproperty
  a_gnt: assert property (p_gnt) else $error("internal grant wrong");
  property p_pend; pri_end_req |-> pri_busy && !pri_gnt; endproperty
  a_pend: assert property (p_pend) else $error("primary end while granted");
  property p_send; sec_end_req |-> sec_busy && !sec_gnt_int; endproperty
  a_send: assert property (p_send) else $error("secondary end while granted");
endmodule : bridge_hdr_chk
bind bridge_config_header_regs bridge_hdr_chk chk_u (.clk(clk), .rst_n(rst_n), .cfg_req(cfg_req),
  .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .cfg_in_bridge_layout(cfg_in_bridge_layout),
  .pri_busy(pri_busy), .pri_gnt(pri_gnt), .pri_end_req(pri_end_req), .sec_busy(sec_busy),
  .sec_own_grant(sec_own_grant), .sec_other_req(sec_other_req), .sec_gnt_int(sec_gnt_int),
  .sec_end_req(sec_end_req), .io_bot_upper(io_bot_upper), .io_win_bot(io_win_bot), .io_win_top(io_win_top));

// ==== test/cfg_host_model.sv ====
// Host model issuing one config access per call
// Assumes cfg_ack is valid just after the edge that takes the request
`timescale 1ns/1ps
module cfg_host_model
  import bridge_cfg_pkg::*;
(
  // Clock
  input wire logic clk,
  // Access port
  output cfg_req_s cfg_req,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_ack
);
  // Idle request
  initial cfg_req = '0;
  // One access; released data turns inverse
  task automatic access(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
      output logic [31:0] rd, output logic ak);
    @(posedge clk);
    #1 cfg_req = '{1'b1, w, a, be, d};
    @(posedge clk);
    #1 cfg_req = '{1'b0, ~w, ~a, ~be, ~d};
    rd = cfg_rdata;
    ak = cfg_ack;
  endtask : access
endmodule : cfg_host_model

// ==== test/bridge_config_header_regs_tb.sv ====
// Testbench for the bridge header bank
// Assumes the host model drives the config port
`timescale 1ns/1ps
module bridge_config_header_regs_tb
  import bridge_cfg_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  cfg_req_s cfg_req;
  logic [31:0] cfg_rdata;
  logic cfg_ack;
  logic in_lay;
  logic pfs = 1'b0, pbusy = 1'b0, pgnt = 1'b1, pend;
  logic sfs = 1'b0, sbusy = 1'b0, sown = 1'b1, soth = 1'b0, sgnt, send;
  fwd_req_s fwd_req = '0;
  fwd_kind_e fwd_kind;
  logic [15:0] bup = 16'h1234, tup = 16'hABCD;
  logic [31:0] wbot, wtop;
  fwd_kind_e fwd_exp [5] = '{FWD_NONE, FWD_TYPE0, FWD_TYPE1, FWD_TYPE1, FWD_NONE};
  int n_errors = 0;
  int compares = 0;
  int i;
  always #4 clk = ~clk;
  cfg_host_model host_u (.clk(clk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack));
  bridge_config_header_regs dut_u (.clk(clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack), .cfg_in_bridge_layout(in_lay), .pri_frame_start(pfs), .pri_busy(pbusy),
    .pri_gnt(pgnt), .pri_end_req(pend), .sec_frame_start(sfs), .sec_busy(sbusy), .sec_own_grant(sown),
    .sec_other_req(soth), .sec_gnt_int(sgnt), .sec_end_req(send), .fwd_req(fwd_req), .fwd_kind(fwd_kind),
    .io_bot_upper(bup), .io_top_upper(tup), .io_win_bot(wbot), .io_win_top(wtop));
  // Compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // Verdict and end of run
  task automatic close_out();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  // Step n edges, then settle
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // One register write or read; read data checked
  task automatic rw(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] r;
    logic ak;
    host_u.access(w, a, be, d, r, ak);
    chk("ack", 32'h1, {31'h0, ak});
    if (!w) chk("rdata", d, r);
  endtask : rw
  initial begin
    #100000;
    n_errors++;
    close_out();
  end
  initial begin
    tick(16);
    rst_n = 1'b1;
    rw(0, 8'h0C, 4'hF, 32'h0001_0000);
    rw(0, 8'h18, 4'hF, 32'h0);
    rw(0, 8'h1C, 4'hF, 32'h0000_0101);
    rw(1, 8'h0C, 4'hF, 32'hFFFF_02FF);
    rw(0, 8'h0C, 4'hF, 32'h0001_0200);
    rw(1, 8'h10, 4'hF, 32'hFFFF_FFFF);
    rw(1, 8'h14, 4'hF, 32'hFFFF_FFFF);
    rw(0, 8'h10, 4'hF, 32'h0);
    rw(0, 8'h14, 4'hF, 32'h0);
    rw(0, 8'h20, 4'hF, 32'h0);
    rw(1, 8'h18, 4'hF, 32'h1006_0903);
    rw(1, 8'h18, 4'h2, 32'hEEEE_04EE);
    rw(0, 8'h18, 4'hF, 32'h1006_0403);
    // Valid held up across the bus sweep
    for (i = 0; i < 5; i++) begin
      fwd_req = '{1'b1, 8'(i + 3)};
      tick(1);
      chk("fwd", {30'h0, fwd_exp[i]}, {30'h0, fwd_kind});
    end
    fwd_req.valid = 1'b0;
    rw(1, 8'h1C, 4'h3, 32'h0000_3F2E);
    rw(0, 8'h1C, 4'hF, 32'h0000_3121);
    chk("wbot", 32'h1234_2000, wbot);
    chk("wtop", 32'hABCD_3FFF, wtop);
    pfs = 1'b1;
    pbusy = 1'b1;
    pgnt = 1'b0;
    tick(1);
    pfs = 1'b0;
    chk("pend0", 32'h0, {31'h0, pend});
    for (i = 0; i < 8 && pend !== 1'b1; i++) tick(1);
    chk("pwait", 32'h3, 32'(i));
    pgnt = 1'b1;
    tick(1);
    chk("pend1", 32'h0, {31'h0, pend});
    pbusy = 1'b0;
    sfs = 1'b1;
    sbusy = 1'b1;
    tick(1);
    sfs = 1'b0;
    tick(20);
    chk("sgnt1", 32'h1, {31'h0, sgnt});
    chk("send0", 32'h0, {31'h0, send});
    soth = 1'b1;
    tick(2);
    chk("sgnt0", 32'h0, {31'h0, sgnt});
    chk("send1", 32'h1, {31'h0, send});
    sbusy = 1'b0;
    // Mid-run reset returns written fields to reset values
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    rw(0, 8'h18, 4'hF, 32'h0);
    rw(0, 8'h0C, 4'hF, 32'h0001_0000);
    rw(0, 8'h1C, 4'hF, 32'h0000_0101);
    chk("wbot_rst", 32'h1234_0000, wbot);
    close_out();
  end
endmodule : bridge_config_header_regs_tb
